//--- hw/led_torch_pkg.sv
// Package: register map, field layout, reset values and scale constants
// Assumes one 50 MHz clock domain and byte-wide register access.
package led_torch_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_LED2_STEADY_CURRENT = 8'h07;
	localparam logic [7:0] ADDR_LIGHT_MODE_SELECT = 8'h08;
	localparam logic [7:0] ADDR_RADIO_BURST_A_LIMIT = 8'h09;

	localparam logic [7:0] RST_LED2_STEADY_CURRENT = 8'h00;
	localparam logic [7:0] RST_LIGHT_MODE_SELECT = 8'hc0;
	localparam logic [7:0] RST_RADIO_BURST_A_LIMIT = 8'hc0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int STEADY_ENABLE_BIT = 7;
	localparam int DIMMING_SELECT_BIT = 0;
	localparam int LEVEL_LSB = 1;
	localparam int STEADY_PULLDOWN_BIT = 7;
	localparam int STROBE_PULLDOWN_BIT = 6;
	localparam int STEADY_MODE_LSB = 3;
	localparam int FLASH_MODE_LSB = 0;
	localparam int BURST_ENABLE_BIT = 7;
	localparam int BURST_PULLDOWN_BIT = 6;
	localparam int CAP_LSB = 0;

	// ----------------------------------------------------------------
	// Trigger-mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] TRIG_OFF = 3'h0;
	localparam logic [2:0] TRIG_STEADY_PIN = 3'h1;
	localparam logic [2:0] TRIG_STROBE_PIN = 3'h2;
	localparam logic [2:0] TRIG_EITHER = 3'h3;
	localparam logic [2:0] TRIG_BOTH = 3'h4;

	// ----------------------------------------------------------------
	// Current scales in microamps, duty in thousandths of a percent
	// ----------------------------------------------------------------
	localparam logic [19:0] DAC_STEP_UA = 20'd3906;
	localparam logic [19:0] DAC_MAX_UA = 20'd250000;
	localparam logic [19:0] PWM_AMP_STEP_UA = 20'd125000;
	localparam logic [19:0] DUTY_STEP_MPCT = 20'd3125;
	localparam logic [19:0] FLASH_STEP_NA16 = 20'd15625;

	typedef enum logic {DIM_DAC, DIM_PWM} dimming_t;

endpackage : led_torch_pkg

//--- hw/trigger_decode.sv
// Decodes a 3-bit trigger-mode field against the two logic pins.
// Assumes the pins are already synchronised.
module trigger_decode (
	input wire logic [2:0] mode,
	input wire logic steadyPin,
	input wire logic strobePin,
	output logic active
);
	import led_torch_pkg::*;

	wire logic isOff = (mode == TRIG_OFF);
	wire logic isSteady = (mode == TRIG_STEADY_PIN);
	wire logic isStrobe = (mode == TRIG_STROBE_PIN);
	wire logic isEither = (mode == TRIG_EITHER);
	wire logic isBoth = (mode == TRIG_BOTH);
	// Codes 101..111 force the mode on
	wire logic isForced = ~(isOff | isSteady | isStrobe | isEither | isBoth);

	assign active = (isSteady & steadyPin) | (isStrobe & strobePin)
		| (isEither & (steadyPin | strobePin)) | (isBoth & steadyPin & strobePin)
		| isForced;
endmodule // trigger_decode

//--- hw/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes single clock; the first stage feeds only the second.
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync WIDTH must be at least 1");
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // pin_sync

//--- hw/led_torch_mode_mask_regs.sv
// Steady-current, mode-select and radio-burst limit registers of the LED driver.
// Assumes a byte-wide register port driven by the serial interface logic.
module led_torch_mode_mask_regs (
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRvalid,
	output logic regAddrHit,
	// Pins, fault levels and the programmed flash code
	input wire logic steadyPin,
	input wire logic strobePin,
	input wire logic radioBurstAInput,
	input wire logic undervoltageLockout,
	input wire logic supplyBelowLockout,
	input wire logic led2SteadyFault,
	input wire logic thermalFault,
	input wire logic overvoltageFault,
	input wire logic [5:0] flashCurrentCode,
	// Control outputs
	output logic led2SteadyEnable,
	output logic led2Regulator,
	output led_torch_pkg::dimming_t led2DimmingSelect,
	output logic [19:0] led2DacCurrentUa,
	output logic [19:0] led2PwmAmplitudeUa,
	output logic [19:0] led2PwmDutyMpct,
	output logic steadyPinPulldown,
	output logic strobePinPulldown,
	output logic radioBurstAPulldown,
	output logic steadyModeActive,
	output logic flashModeActive,
	output logic burstCapActive,
	output logic [5:0] flashCurrentApplied,
	output logic [19:0] radioBurstACurrentCapUa
);
	import led_torch_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [2:0] syncPins;
	logic steadyPinS, strobePinS, burstPinS;
	logic underS, faultS;

	// Faults are combined after sync so each bit has its own two flops
	logic [4:0] faultPins;
	logic [4:0] faultSync;
	assign faultPins = {undervoltageLockout, supplyBelowLockout, led2SteadyFault, thermalFault,
		overvoltageFault};

	pin_sync #(.WIDTH(3)) uPinSync (
		.clock(clock),
		.srst(srst),
		.asyncIn({steadyPin, strobePin, radioBurstAInput}),
		.syncOut(syncPins[2:0])
	);

	pin_sync #(.WIDTH(5)) uFaultSync (
		.clock(clock),
		.srst(srst),
		.asyncIn(faultPins),
		.syncOut(faultSync)
	);

	assign steadyPinS = syncPins[2];
	assign strobePinS = syncPins[1];
	assign burstPinS = syncPins[0];

	wire logic lockoutS = faultSync[4] | faultSync[3];
	wire logic led2FaultS = faultSync[2];
	wire logic thermS = faultSync[1];
	wire logic ovpS = faultSync[0];
	assign underS = lockoutS;
	assign faultS = thermS | ovpS;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic [7:0] steadyCur_q, steadyCur_d;
	logic [7:0] modeSel_q, modeSel_d;
	logic [7:0] burstLim_q, burstLim_d;

	wire logic hitSteady = (regAddr == ADDR_LED2_STEADY_CURRENT);
	wire logic hitMode = (regAddr == ADDR_LIGHT_MODE_SELECT);
	wire logic hitBurst = (regAddr == ADDR_RADIO_BURST_A_LIMIT);
	wire logic wrSteady = regWrite & hitSteady;
	wire logic wrMode = regWrite & hitMode;
	wire logic wrBurst = regWrite & hitBurst;

	assign regAddrHit = hitSteady | hitMode | hitBurst;

	// ----------------------------------------------------------------
	// Next-state values
	// ----------------------------------------------------------------
	// Fault clear beats a write in the same cycle so a fault cannot be masked
	wire logic clearSteadyEn = underS | led2FaultS;
	wire logic clearModes = underS | faultS;
	wire logic [7:0] steadyWr = wrSteady ? regWdata : steadyCur_q;
	wire logic [7:0] modeWr = wrMode ? regWdata : modeSel_q;

	assign steadyCur_d = {steadyWr[7] & ~clearSteadyEn, steadyWr[6:0]};
	assign modeSel_d = clearModes ? {modeWr[7:6], 6'h00} : modeWr;
	// Burst register returns to its reset value on supply lockout
	assign burstLim_d = lockoutS ? RST_RADIO_BURST_A_LIMIT : (wrBurst ? regWdata : burstLim_q);

	always_ff @(posedge clock) begin
		if (srst) begin
			steadyCur_q <= RST_LED2_STEADY_CURRENT;
		end else begin
			steadyCur_q <= steadyCur_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			modeSel_q <= RST_LIGHT_MODE_SELECT;
		end else begin
			modeSel_q <= modeSel_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			burstLim_q <= RST_RADIO_BURST_A_LIMIT;
		end else begin
			burstLim_q <= burstLim_d;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero
	wire logic [7:0] rdMux = hitSteady ? steadyCur_q :
		hitMode ? modeSel_q :
		hitBurst ? burstLim_q : 8'h00;

	// Data holds until the next read; valid is a one-cycle pulse
	always_ff @(posedge clock) begin
		if (srst) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= regRead ? rdMux : regRdata;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
		end
	end

	// ----------------------------------------------------------------
	// Steady-current decode
	// ----------------------------------------------------------------
	wire logic [5:0] level = steadyCur_q[LEVEL_LSB+5:LEVEL_LSB];
	wire logic pwmSel = steadyCur_q[DIMMING_SELECT_BIT];
	wire logic [19:0] levelWide = {14'h0000, level};
	wire logic [19:0] ampWide = {17'h00000, level[2:0]};
	wire logic [19:0] dutyWide = {17'h00000, level[5:3]};
	wire logic [19:0] dacUa = (level == 6'h3f) ? DAC_MAX_UA : 20'((levelWide + 20'd1) * DAC_STEP_UA);
	wire logic [19:0] ampUa = 20'((ampWide + 20'd1) * PWM_AMP_STEP_UA);
	wire logic [19:0] dutyMpct = 20'((dutyWide + 20'd1) * DUTY_STEP_MPCT);

	// ----------------------------------------------------------------
	// Trigger decode
	// ----------------------------------------------------------------
	logic steadyTrig, flashTrig;

	trigger_decode uSteadyDecode (
		.mode(modeSel_q[STEADY_MODE_LSB+2:STEADY_MODE_LSB]),
		.steadyPin(steadyPinS),
		.strobePin(strobePinS),
		.active(steadyTrig)
	);

	trigger_decode uFlashDecode (
		.mode(modeSel_q[FLASH_MODE_LSB+2:FLASH_MODE_LSB]),
		.steadyPin(steadyPinS),
		.strobePin(strobePinS),
		.active(flashTrig)
	);

	// ----------------------------------------------------------------
	// Radio burst cap
	// ----------------------------------------------------------------
	wire logic [5:0] capCode = burstLim_q[CAP_LSB+5:CAP_LSB];
	wire logic burstOn = burstLim_q[BURST_ENABLE_BIT] & burstPinS;
	wire logic [19:0] capWide = {14'h0000, capCode};
	// Step is a whole number of microamps, so the scale is exact
	wire logic [19:0] capUa = 20'((capWide + 20'd1) * FLASH_STEP_NA16);
	wire logic [5:0] minCode = (capCode < flashCurrentCode) ? capCode : flashCurrentCode;
	// Host is expected to program registers before raising pins
	wire logic [5:0] flashApplied = burstOn ? minCode : flashCurrentCode;

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			led2SteadyEnable <= 1'b0;
		end else begin
			led2SteadyEnable <= steadyCur_q[STEADY_ENABLE_BIT];
		end
	end

	// Regulator runs only while enabled and the steady trigger is active
	always_ff @(posedge clock) begin
		if (srst) begin
			led2Regulator <= 1'b0;
		end else begin
			led2Regulator <= steadyCur_q[STEADY_ENABLE_BIT] & steadyTrig;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			led2DimmingSelect <= DIM_DAC;
		end else begin
			led2DimmingSelect <= pwmSel ? DIM_PWM : DIM_DAC;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			led2DacCurrentUa <= 20'h00000;
		end else begin
			led2DacCurrentUa <= dacUa;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			led2PwmAmplitudeUa <= 20'h00000;
		end else begin
			led2PwmAmplitudeUa <= ampUa;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			led2PwmDutyMpct <= 20'h00000;
		end else begin
			led2PwmDutyMpct <= dutyMpct;
		end
	end

	// Pin pulldowns follow the mode register, burst pulldown the burst register, one edge after a write
	always_ff @(posedge clock) begin
		if (srst) begin
			steadyPinPulldown <= 1'b0;
		end else begin
			steadyPinPulldown <= modeSel_q[STEADY_PULLDOWN_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			strobePinPulldown <= 1'b0;
		end else begin
			strobePinPulldown <= modeSel_q[STROBE_PULLDOWN_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			radioBurstAPulldown <= 1'b0;
		end else begin
			radioBurstAPulldown <= burstLim_q[BURST_PULLDOWN_BIT];
		end
	end

	// Trigger outputs lag the pins by three edges: two sync, one flop
	always_ff @(posedge clock) begin
		if (srst) begin
			steadyModeActive <= 1'b0;
		end else begin
			steadyModeActive <= steadyTrig;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			flashModeActive <= 1'b0;
		end else begin
			flashModeActive <= flashTrig;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			burstCapActive <= 1'b0;
		end else begin
			burstCapActive <= burstOn;
		end
	end

	// Applied code uses the live programmed code, one edge behind it
	always_ff @(posedge clock) begin
		if (srst) begin
			flashCurrentApplied <= 6'h00;
		end else begin
			flashCurrentApplied <= flashApplied;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			radioBurstACurrentCapUa <= 20'h00000;
		end else begin
			radioBurstACurrentCapUa <= capUa;
		end
	end
endmodule // led_torch_mode_mask_regs

//--- bench/led_torch_mode_mask_regs_chk.sv
// Checker: port-level assertions for the torch mode and radio-burst registers.
// Assumes one clock domain; attached to the top module by bind.
module led_torch_mode_mask_regs_chk (
	input wire logic clock,
	input wire logic srst,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic led2SteadyFault,
	input wire logic [5:0] flashCurrentCode,
	input wire logic led2SteadyEnable,
	input wire led_torch_pkg::dimming_t led2DimmingSelect,
	input wire logic [19:0] led2DacCurrentUa,
	input wire logic [19:0] led2PwmAmplitudeUa,
	input wire logic strobePinPulldown,
	input wire logic radioBurstAInput,
	input wire logic burstCapActive,
	input wire logic [5:0] flashCurrentApplied
);
	timeunit 1ns;
	timeprecision 1ps;
	import led_torch_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// Write taken two edges back: register one edge, output the next
	sequence s_wr07;
		$past(regWrite, 2) && $past(regAddr, 2) == 8'h07;
	endsequence
	sequence s_wr08;
		$past(regWrite, 2) && $past(regAddr, 2) == 8'h08;
	endsequence
	a_enable_by_write: assert property ($rose(led2SteadyEnable) |-> s_wr07 ##0 $past(regWdata[7], 2))
		else $error("steady enable rose without a write of bit 7");
	a_fault_clears_en: assert property ($past(led2SteadyFault, 4) |-> !led2SteadyEnable)
		else $error("steady enable survived a channel fault");
	a_dac_level: assert property (s_wr07 |-> led2DacCurrentUa == ($past(regWdata[6:1], 2) == 6'h3f ?
		20'd250000 : (20'($past(regWdata[6:1], 2)) + 20'd1) * 20'd3906))
		else $error("linear current does not match level code");
	a_pwm_amplitude: assert property (s_wr07 |->
		led2PwmAmplitudeUa == (20'($past(regWdata[3:1], 2)) + 20'd1) * 20'd125000)
		else $error("pulse amplitude does not match low bits");
	a_dim_select: assert property ($changed(led2DimmingSelect) |->
		s_wr07 ##0 $past(regWdata[0], 2) == led2DimmingSelect)
		else $error("dimming select changed without matching write");
	a_strobe_pd_off: assert property ($fell(strobePinPulldown) |-> s_wr08 ##0 !$past(regWdata[6], 2))
		else $error("strobe pulldown dropped without a write of bit 6");
	a_burst_from_pin: assert property (burstCapActive |-> $past(radioBurstAInput, 3))
		else $error("burst cap active without the burst pin");
	a_applied_cap: assert property (!$past(srst) |->
		flashCurrentApplied <= $past(flashCurrentCode) &&
		(burstCapActive || flashCurrentApplied == $past(flashCurrentCode)))
		else $error("applied flash code above programmed or capped while idle");
endmodule // led_torch_mode_mask_regs_chk

bind led_torch_mode_mask_regs led_torch_mode_mask_regs_chk u_chk (.clock, .srst, .regWrite, .regAddr,
	.regWdata, .led2SteadyFault, .flashCurrentCode, .led2SteadyEnable, .led2DimmingSelect,
	.led2DacCurrentUa, .led2PwmAmplitudeUa, .strobePinPulldown, .radioBurstAInput, .burstCapActive,
	.flashCurrentApplied);

//--- bench/led_host_model.sv
// Host model: byte-port register writes and reads, and the three pin levels.
// Assumes the bench calls its tasks; everything changes on the falling edge.
module led_host_model (
	input wire logic clock,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic steadyPin,
	output logic strobePin,
	output logic radioBurstAInput
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{regWrite, regRead, regAddr, regWdata, steadyPin, strobePin, radioBurstAInput} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clock);
		regWrite = 1'b0;
		// Released data flips so a stale byte is never mistaken for live
		regWdata = ~d;
	endtask
	// Answer is fixed one cycle after the strobe; valid comes back with the data
	task automatic rd(input logic [7:0] a, output logic [8:0] r);
		@(negedge clock);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clock);
		regRead = 1'b0;
		r = {regRvalid, regRdata};
	endtask
	task automatic pins(input logic [2:0] p);
		@(negedge clock);
		{steadyPin, strobePin, radioBurstAInput} = p;
	endtask
endmodule // led_host_model

//--- bench/led_torch_mode_mask_regs_tb_top.sv
// Testbench: registers, trigger decode, burst cap and fault clearing.
// Assumes the checker is bound in; the host model drives the register port and pins.
module led_torch_mode_mask_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, srst, regWrite, regRead, regRvalid, steadyPin, strobePin, radioBurstAInput;
	logic [7:0] regAddr, regWdata, regRdata;
	logic [4:0] fault;
	logic [5:0] flashCurrentCode, flashCurrentApplied;
	logic led2SteadyEnable, steadyPinPulldown, strobePinPulldown, radioBurstAPulldown;
	logic steadyModeActive, flashModeActive, burstCapActive, led2Regulator, regAddrHit;
	logic [19:0] led2DacCurrentUa, led2PwmAmplitudeUa, led2PwmDutyMpct, radioBurstACurrentCapUa;
	led_torch_pkg::dimming_t led2DimmingSelect;
	int fail_count, checks;
	led_torch_mode_mask_regs u_dut (.clock, .srst, .regWrite, .regRead, .regAddr, .regWdata,
		.regRdata, .regRvalid, .regAddrHit, .steadyPin, .strobePin, .radioBurstAInput,
		.undervoltageLockout(fault[0]), .supplyBelowLockout(fault[1]), .led2SteadyFault(fault[2]),
		.thermalFault(fault[3]), .overvoltageFault(fault[4]), .flashCurrentCode, .led2SteadyEnable,
		.led2Regulator, .led2DimmingSelect, .led2DacCurrentUa, .led2PwmAmplitudeUa,
		.led2PwmDutyMpct, .steadyPinPulldown, .strobePinPulldown, .radioBurstAPulldown,
		.steadyModeActive, .flashModeActive, .burstCapActive, .flashCurrentApplied,
		.radioBurstACurrentCapUa);
	led_host_model u_host (.clock, .regRdata, .regRvalid, .regWrite, .regRead, .regAddr,
		.regWdata, .steadyPin, .strobePin, .radioBurstAInput);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic trig(input logic [2:0] c, input logic s, input logic t);
		return c > 3'h4 ? 1'b1 : c == 3'h4 ? s & t : c == 3'h3 ? s | t : c == 3'h2 ? t : c == 3'h1 && s;
	endfunction
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		logic [8:0] r;
		logic [7:0] v;
		logic en;
		srst = 1'b1;
		fault = 5'h00;
		flashCurrentCode = 6'h00;
		fail_count = 0;
		checks = 0;
		void'($urandom(32'h267f3140));
		repeat (10) @(negedge clock);
		srst = 1'b0;
		// Reset values, then an unmapped address that must read as zero
		for (int i = 0; i < 4; i++) begin
			u_host.rd(8'h07 + 8'(i), r);
			check(20'({regAddrHit, r}),
				{10'h000, i != 3, 1'b1, i == 0 || i == 3 ? 8'h00 : 8'hc0});
		end
		check(20'({steadyPinPulldown, strobePinPulldown, radioBurstAPulldown}), 20'h7);
		for (int i = 0; i < 24; i++) begin
			v = i == 0 ? 8'h7e : i == 1 ? 8'hff : 8'($urandom);
			u_host.wr(8'h07, v);
			repeat (2) @(negedge clock);
			check(20'(led2SteadyEnable), 20'(v[7]));
			check(20'(led2DimmingSelect), 20'(v[0]));
			check(led2DacCurrentUa, v[6:1] == 6'h3f ? 20'd250000 : (20'(v[6:1]) + 20'd1) * 20'd3906);
			check(led2PwmAmplitudeUa, (20'(v[3:1]) + 20'd1) * 20'd125000);
			check(led2PwmDutyMpct, (20'(v[6:4]) + 20'd1) * 20'd3125);
		end
		// Every mode code against every pin pair, flash field runs the other way
		for (int c = 0; c < 32; c++) begin
			v = {2'($urandom), 3'(c / 4), 3'(7 - c / 4)};
			en = 1'($urandom);
			u_host.wr(8'h07, {en, 7'h00});
			u_host.wr(8'h08, v);
			u_host.pins({2'(c), 1'b0});
			repeat (4) @(negedge clock);
			check(20'({steadyPinPulldown, strobePinPulldown}), 20'(v[7:6]));
			check(20'(steadyModeActive), 20'(trig(v[5:3], c[1], c[0])));
			check(20'(flashModeActive), 20'(trig(v[2:0], c[1], c[0])));
			check(20'(led2Regulator), 20'(en & trig(v[5:3], c[1], c[0])));
		end
		for (int i = 0; i < 12; i++) begin
			v = i < 2 ? 8'hbf : 8'($urandom);
			flashCurrentCode = 6'($urandom);
			u_host.wr(8'h09, v);
			u_host.pins({2'b00, i[0]});
			repeat (4) @(negedge clock);
			check(20'(radioBurstAPulldown), 20'(v[6]));
			check(20'(burstCapActive), 20'(v[7] & i[0]));
			check(20'(flashCurrentApplied), 20'(v[7] && i[0] && v[5:0] < flashCurrentCode ?
				v[5:0] : flashCurrentCode));
			check(radioBurstACurrentCapUa, (20'(v[5:0]) + 20'd1) * 20'd15625);
		end
		// Each fault alone, held while the registers are read back
		for (int i = 0; i < 5; i++) begin
			u_host.wr(8'h07, 8'hff);
			u_host.wr(8'h08, 8'hff);
			u_host.wr(8'h09, 8'h3f);
			fault = 5'(1 << i);
			repeat (6) @(negedge clock);
			u_host.rd(8'h07, r);
			check(20'(r), {12'h001, i > 2 ? 8'hff : 8'h7f});
			u_host.rd(8'h08, r);
			check(20'(r), {12'h001, i == 2 ? 8'hff : 8'hc0});
			u_host.rd(8'h09, r);
			check(20'(r), {12'h001, i < 2 ? 8'hc0 : 8'h3f});
			fault = 5'h00;
			repeat (4) @(negedge clock);
		end
		// Mid-run reset must bring back the reset values of registers 07 and 09
		srst = 1'b1;
		repeat (3) @(negedge clock);
		srst = 1'b0;
		u_host.rd(8'h07, r);
		check(20'(r), 20'h00100);
		u_host.rd(8'h09, r);
		check(20'(r), 20'h001c0);
		complete_run();
	end
endmodule // led_torch_mode_mask_regs_tb_top
